// file: sgoc_config_decode.v
// configuration byte holder and decoder for segment protection and start-up oscillator
`timescale 1ns/100ps
`include "sgoc_map.vh"
module sgoc_config_decode
(
    input wire clock,
    input wire rstn,
    input wire clock_en,
    input wire [7:0] nv_general_segment_protect_cfg,
    input wire [7:0] nv_oscillator_select_cfg,
    input wire [7:0] nv_oscillator_setup_cfg,
    input wire prog_gs_we,
    input wire [7:0] prog_gs_data,
    input wire prog_os_we,
    input wire [7:0] prog_os_data,
    input wire prog_su_we,
    input wire [7:0] prog_su_data,
    output reg [7:0] general_segment_protect_cfg,
    output reg [7:0] oscillator_select_cfg,
    output reg [7:0] oscillator_setup_cfg,
    output reg general_seg_code_protect,
    output reg general_seg_write_protect,
    output reg general_seg_write_allowed,
    output reg two_speed_startup_en,
    output reg [2:0] startup_osc_select,
    output reg [7:0] startup_src_onehot,
    output reg clock_switch_en,
    output reg fail_safe_monitor_en
);

// ----------------------------------------
// nonvolatile cell model
// ----------------------------------------
// cells load the nv bytes in reset; the programmer may only clear bits of the protect cell (and with the array); select and setup writes replace the cell
reg [7:0] cell_gs;
reg [7:0] cell_os;
reg [7:0] cell_su;
reg in_reset;

// next cell values, worked out apart from the flops
reg [7:0] next_cell_gs;
reg [7:0] next_cell_os;
reg [7:0] next_cell_su;

// decoded fields of the cells, ahead of the output latch
wire gs_code_bit;
wire gs_write_bit;
wire os_two_speed_bit;
wire [2:0] os_source;
wire su_csm_high;
wire su_csm_low;
wire [7:0] next_src_onehot;
wire latch_now;

// ----------------------------------------
// protect cell next value
// ----------------------------------------
// a write can only clear bits; the and with the old cell keeps it one-way
always @*
begin
    next_cell_gs = cell_gs;
    if (prog_gs_we)
    begin
        next_cell_gs = cell_gs & prog_gs_data & `SGOC_GS_IMPL_MASK;
    end
    else if (in_reset)
    begin
        next_cell_gs = nv_general_segment_protect_cfg & `SGOC_GS_IMPL_MASK;
    end
end

// ----------------------------------------
// select cell next value
// ----------------------------------------
// only the implemented bits are kept, so pads stay zero in the cell
always @*
begin
    next_cell_os = cell_os;
    if (prog_os_we)
    begin
        next_cell_os = prog_os_data & `SGOC_OS_IMPL_MASK;
    end
    else if (in_reset)
    begin
        next_cell_os = nv_oscillator_select_cfg & `SGOC_OS_IMPL_MASK;
    end
end

// ----------------------------------------
// setup cell next value
// ----------------------------------------
// all eight setup bits are implemented; no mask needed
always @*
begin
    next_cell_su = cell_su;
    if (prog_su_we)
    begin
        next_cell_su = prog_su_data;
    end
    else if (in_reset)
    begin
        next_cell_su = nv_oscillator_setup_cfg;
    end
end

// ----------------------------------------
// cell flops
// ----------------------------------------
// a write in the same cycle as the reset load wins over the load
always @(posedge clock)
begin
    if (clock_en)
    begin
        cell_gs <= next_cell_gs;
        cell_os <= next_cell_os;
        cell_su <= next_cell_su;
    end
end

// load marker lags rstn one edge, so reset must last three edges
always @(posedge clock)
begin
    if (clock_en)
    begin
        in_reset <= ~rstn;
    end
end

// ----------------------------------------
// field extraction
// ----------------------------------------
// plain wiring of the cell bits to named fields
assign gs_code_bit = cell_gs[`SGOC_GS_CP_BIT];
assign gs_write_bit = cell_gs[`SGOC_GS_WRP_BIT];
assign os_two_speed_bit = cell_os[`SGOC_OS_TSS_BIT];
assign os_source = cell_os[`SGOC_OS_SEL_MSB:`SGOC_OS_SEL_LSB];
assign su_csm_high = cell_su[`SGOC_SU_CSM_MSB];
assign su_csm_low = cell_su[`SGOC_SU_CSM_LSB];

// outputs move only while rstn is low and the clock is enabled
assign latch_now = clock_en & ~rstn;

// ----------------------------------------
// source one-hot decode
// ----------------------------------------
// one compare per source code; every code has a meaning, so no reserved bit
genvar src_idx;
generate
    for (src_idx = 0; src_idx < 8; src_idx = src_idx + 1)
    begin : g_src
        localparam [2:0] SRC_CODE = src_idx;
        assign next_src_onehot[src_idx] = (os_source == SRC_CODE);
    end
endgenerate

// ----------------------------------------
// readback bytes
// ----------------------------------------
// decodes move only in reset, so programming never disturbs a running part
always @(posedge clock)
begin
    if (latch_now)
    begin
        general_segment_protect_cfg <= cell_gs & `SGOC_GS_IMPL_MASK;
        oscillator_select_cfg <= cell_os & `SGOC_OS_IMPL_MASK;
        oscillator_setup_cfg <= cell_su;
    end
end

// ----------------------------------------
// segment protection decode
// ----------------------------------------
// both senses of write protect are given, so flash logic needs no inverter
always @(posedge clock)
begin
    if (latch_now)
    begin
        general_seg_code_protect <= ~gs_code_bit;
        general_seg_write_protect <= ~gs_write_bit;
        general_seg_write_allowed <= gs_write_bit;
    end
end

// ----------------------------------------
// start-up oscillator decode
// ----------------------------------------
// code and one-hot both held; clock control may use either form
always @(posedge clock)
begin
    if (latch_now)
    begin
        two_speed_startup_en <= os_two_speed_bit;
        startup_osc_select <= os_source;
        startup_src_onehot <= next_src_onehot;
    end
end

// ----------------------------------------
// clock switch and monitor decode
// ----------------------------------------
// high field bit set turns both off, whatever the low bit holds
always @(posedge clock)
begin
    if (latch_now)
    begin
        clock_switch_en <= ~su_csm_high;
        fail_safe_monitor_en <= ~su_csm_high & ~su_csm_low;
    end
end

// limitation: outputs are unknown until the first reset with the clock enabled
endmodule

// file: sgoc_config_decode_asserts.sv
// checker of the decoded configuration outputs
`timescale 1ns/100ps
module sgoc_chk(input wire clock, rstn, clock_en, general_seg_code_protect, general_seg_write_protect,
    general_seg_write_allowed, two_speed_startup_en, clock_switch_en, fail_safe_monitor_en,
    input wire [2:0] startup_osc_select, input wire [7:0] general_segment_protect_cfg,
    oscillator_select_cfg, oscillator_setup_cfg, startup_src_onehot);
wire [7:0] g = general_segment_protect_cfg, o = oscillator_select_cfg, s = oscillator_setup_cfg;
default clocking @(posedge clock); endclocking
default disable iff (!rstn);
a_gs_pad: assert property (g[7:2] == 6'h00) else $error("pad");
a_os_pad: assert property (o[6:3] == 4'h0) else $error("pad");
a_code_prot: assert property (general_seg_code_protect != g[1]) else $error("cp");
a_write_prot: assert property ({general_seg_write_protect, general_seg_write_allowed} == {~g[0], g[0]})
    else $error("wp");
a_two_speed: assert property (two_speed_startup_en == o[7]) else $error("ts");
a_src_sel: assert property ({startup_osc_select, startup_src_onehot} == {o[2:0], 8'h01 << o[2:0]})
    else $error("src");
a_csm_dec: assert property ({clock_switch_en, fail_safe_monitor_en} == {~s[7], s[7:6] == 2'h0})
    else $error("csm");
// held from release on: the first edge after release is skipped by the past term
a_run_hold: assert property ($past(rstn) |-> $stable({g, o, s, startup_src_onehot}))
    else $error("hold");
sequence s_frozen_edge;
    !clock_en;
endsequence
a_en_freeze: assert property (s_frozen_edge |=> $stable({g, o, s, startup_src_onehot}))
    else $error("freeze");
endmodule
bind sgoc_config_decode sgoc_chk i_sgoc_chk(.*);

// file: sgoc_config_decode_test.sv
// random and corner bench for the configuration decoder
`timescale 1ns/100ps
module sgoc_config_decode_test;
reg clock = 0, rstn = 0, clock_en = 1, prog_gs_we = 0, prog_os_we = 0, prog_su_we = 0;
reg [7:0] nv_general_segment_protect_cfg, nv_oscillator_select_cfg, nv_oscillator_setup_cfg;
reg [7:0] prog_gs_data, prog_os_data, prog_su_data;
wire [7:0] general_segment_protect_cfg, oscillator_select_cfg, oscillator_setup_cfg;
wire [7:0] startup_src_onehot;
wire [2:0] startup_osc_select;
wire general_seg_code_protect, general_seg_write_protect, general_seg_write_allowed;
wire two_speed_startup_en, clock_switch_en, fail_safe_monitor_en;
reg [23:0] k;
integer bad_count = 0, n_checks = 0, i;
wire [7:0] dec_seen = {2'h0, general_seg_code_protect, general_seg_write_protect,
    general_seg_write_allowed, two_speed_startup_en, clock_switch_en, fail_safe_monitor_en};
function [7:0] exp_dec(input [23:0] v);
    exp_dec = {2'h0, ~v[17], ~v[16], v[16], v[15], ~v[7], v[7:6] == 2'h0};
endfunction
sgoc_config_decode i_sgoc_config_decode(.*);
task chk(input [15:0] nm, input [7:0] seen, input [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask
task wrap_up;
    $display("%0d mismatches in %0d checks", bad_count, n_checks);
    if (bad_count == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
initial forever #2 clock = ~clock;
// run needs about 2.3 us; a hang is cut well after that
initial
begin
    #8000 bad_count = bad_count + 1;
    wrap_up;
end
initial
begin
    i = $urandom(30627);
    for (i = 0; i < 40; i = i + 1)
    begin
        // erased bytes first, fully programmed bytes second, then random
        k = i == 0 ? 24'hFFFFFF : i == 1 ? 24'h000000 : $urandom;
        rstn = 0;
        {nv_general_segment_protect_cfg, nv_oscillator_select_cfg, nv_oscillator_setup_cfg} = k;
        {prog_gs_data, prog_os_data, prog_su_data} = $urandom;
        repeat (i == 0 ? 16 : 4) @(negedge clock);
        rstn = 1;
        repeat (2) @(negedge clock);
        // stored bytes change after release and must not reach the outputs
        {nv_general_segment_protect_cfg, nv_oscillator_select_cfg, nv_oscillator_setup_cfg} = ~k;
        repeat (2) @(negedge clock);
        chk("gs", general_segment_protect_cfg, {6'h00, k[17:16]});
        chk("os", oscillator_select_cfg, k[15:8] & 8'h87);
        chk("su", oscillator_setup_cfg, k[7:0]);
        chk("dc", dec_seen, exp_dec(k));
        chk("oh", startup_src_onehot, 8'h01 << k[10:8]);
        // program all cells, then a one-edge reset shows them before the reload
        prog_gs_we = 1;
        prog_os_we = 1;
        prog_su_we = 1;
        @(negedge clock);
        {prog_gs_we, prog_os_we, prog_su_we} = 3'h0;
        rstn = 0;
        @(negedge clock);
        rstn = 1;
        @(negedge clock);
        chk("pg", general_segment_protect_cfg, {6'h00, k[17:16] & prog_gs_data[1:0]});
        chk("po", oscillator_select_cfg, prog_os_data & 8'h87);
        chk("ps", oscillator_setup_cfg, prog_su_data);
        // reset with the clock disabled must leave the setup readback byte frozen
        clock_en = 0;
        rstn = 0;
        repeat (2) @(negedge clock);
        rstn = 1;
        @(negedge clock);
        clock_en = 1;
        chk("fz", oscillator_setup_cfg, prog_su_data);
    end
    wrap_up;
end
endmodule

// file: sgoc_map.vh
// bit positions, erased values and decode codes for the configuration decoder
`ifndef SGOC_MAP_VH
`define SGOC_MAP_VH
`define SGOC_GS_WRP_BIT 0
`define SGOC_GS_CP_BIT 1
`define SGOC_GS_IMPL_MASK 8'h03
`define SGOC_OS_SEL_LSB 0
`define SGOC_OS_SEL_MSB 2
`define SGOC_OS_TSS_BIT 7
`define SGOC_OS_IMPL_MASK 8'h87
`define SGOC_SU_CSM_LSB 6
`define SGOC_SU_CSM_MSB 7
`define SGOC_ERASED 8'hFF
`define SGOC_SRC_FRC 3'h0
`define SGOC_SRC_FRC_DIV_PLL 3'h1
`define SGOC_SRC_PRI 3'h2
`define SGOC_SRC_PRI_PLL 3'h3
`define SGOC_SRC_SEC 3'h4
`define SGOC_SRC_LOW_POWER_INTERNAL_RC 3'h5
`define SGOC_SRC_LPFRC_DIV 3'h6
`define SGOC_SRC_FRC_DIV 3'h7
`endif
